//--- core/fsq_pkg.sv
// Purpose: shared constants and types for the flash erase/program sequencer
// Assumes: 24-bit byte addresses and a 16-bit CPU data path
// Notes: register offsets are byte addresses on the internal memory bus
package fsq_pkg;
  // Main array windows in CPU space
  localparam logic [23:0] PROG_MAIN_BASE = 24'h00_0000;
  localparam logic [23:0] PROG_MAIN_END = 24'h03_FFFF;
  localparam logic [23:0] DATA_MAIN_BASE = 24'h0D_0000;
  localparam logic [23:0] DATA_MAIN_END = 24'h0D_1FFF;
  // Program flash interface registers
  localparam logic [23:0] OFF_P_INFO_ADDR = 24'hFF_F940;
  localparam logic [23:0] OFF_P_INFO_WORD = 24'hFF_F942;
  localparam logic [23:0] OFF_P_WEN0 = 24'hFF_F944;
  localparam logic [23:0] OFF_P_WEN1 = 24'hFF_F946;
  localparam logic [23:0] OFF_P_CTRL = 24'hFF_F94C;
  localparam logic [23:0] OFF_P_STAT = 24'hFF_F94E;
  localparam logic [23:0] OFF_P_MIRROR = 24'hFF_F964;
  // Data flash interface registers
  localparam logic [23:0] OFF_D_INFO_ADDR = 24'hFF_F740;
  localparam logic [23:0] OFF_D_INFO_WORD = 24'hFF_F742;
  localparam logic [23:0] OFF_D_WEN = 24'hFF_F744;
  localparam logic [23:0] OFF_D_CTRL = 24'hFF_F74C;
  localparam logic [23:0] OFF_D_STAT = 24'hFF_F74E;
  // Control register fields
  localparam int CTRL_PROG_EN = 1;
  localparam int CTRL_PAGE_ER = 2;
  localparam int CTRL_BLOCK_ER = 3;
  localparam logic [15:0] CTRL_MASK = 16'h000E;
  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_EFAIL = 1;
  localparam int STAT_PFAIL = 2;
  localparam int STAT_FULL = 3;
  // Dedicated info words (word index inside the program info array)
  localparam logic [6:0] FW_WORD = 7'h3F;
  localparam logic [6:0] PW_WORD = 7'h7F;
  localparam int FW_USB_EN = 0;
  localparam int PW_WRP_MSB = 15;
  localparam int PW_WRP_LSB = 13;
  localparam int PW_BOOT_MSB = 4;
  localparam int PW_BOOT_LSB = 1;
  // Reset values
  localparam logic [15:0] REG_RST = 16'h0000;
  // Cycles one word programming operation occupies the array
  localparam int PROG_CYC = 8;
  // Array commands
  typedef enum logic [2:0] {
    CMD_PAGE = 3'b000,
    CMD_BLOCK = 3'b001,
    CMD_INFO = 3'b010,
    CMD_PMAIN = 3'b011,
    CMD_PINFO = 3'b100
  } fsq_cmd_t;
  // Engine states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG = 2'b10
  } fsq_st_t;
  // Reset-time loader states
  typedef enum logic [1:0] {
    LD_FW = 2'b00,
    LD_PW = 2'b01,
    LD_DONE = 2'b10
  } fsq_ld_t;
endpackage

//--- core/fsq_engine.sv
// Purpose: one flash array with its erase walker and two-deep program pipeline
// Assumes: caller only issues erase while idle and program while not full
// Notes: memories carry no reset; their content survives a system reset
`timescale 1ns/1ps
module fsq_engine #(
  parameter int MAIN_AW = 17,
  parameter int BLK_AW = 16,
  parameter int PAGE_AW = 9,
  parameter int INFO_AW = 7,
  parameter int IBLK_AW = 6,
  parameter int PROG_CYC = fsq_pkg::PROG_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command
  input wire logic cmd_valid_i,
  input wire fsq_pkg::fsq_cmd_t cmd_kind_i,
  input wire logic [MAIN_AW-1:0] cmd_addr_i,
  input wire logic [INFO_AW-1:0] cmd_iaddr_i,
  input wire logic [15:0] cmd_data_i,
  // Status
  output logic busy_o,
  output logic full_o,
  // Read ports
  input wire logic [MAIN_AW-1:0] main_raddr_i,
  output logic [15:0] main_rdata_o,
  input wire logic [INFO_AW-1:0] info_raddr_i,
  output logic [15:0] info_rdata_o
);
  logic [15:0] main_mem [2**MAIN_AW]; // Main array words
  logic [15:0] info_mem [2**INFO_AW]; // Info array words
  fsq_pkg::fsq_st_t st; // Engine state
  logic [BLK_AW-1:0] cnt; // Erase index or program timer
  logic [BLK_AW-1:0] mask; // Last erase index
  logic [MAIN_AW-1:0] base; // Erase region address
  logic [INFO_AW-1:0] ibase; // Info erase address
  logic er_info; // Info block joins the erase
  logic q_valid; // Pipeline slot occupied
  logic q_info;
  logic [MAIN_AW-1:0] q_addr;
  logic [INFO_AW-1:0] q_iaddr;
  logic [15:0] q_data;
  logic a_info; // Word being programmed now
  logic [MAIN_AW-1:0] a_addr;
  logic [INFO_AW-1:0] a_iaddr;
  logic [15:0] a_data;
  localparam logic [BLK_AW-1:0] PG_MASK = BLK_AW'(2**PAGE_AW - 1);
  localparam logic [INFO_AW-1:0] I_MASK = INFO_AW'(2**IBLK_AW - 1);
  localparam logic [BLK_AW-1:0] P_LAST = BLK_AW'(PROG_CYC - 1);

  wire is_prog = (cmd_kind_i == fsq_pkg::CMD_PMAIN) || (cmd_kind_i == fsq_pkg::CMD_PINFO);
  wire er_last = (cnt == mask);
  wire pr_last = (cnt == P_LAST);
  wire [MAIN_AW-1:0] er_addr = (base & ~MAIN_AW'(mask)) | MAIN_AW'(cnt);
  wire [INFO_AW-1:0] ier_addr = (ibase & ~I_MASK) | (INFO_AW'(cnt) & I_MASK);
  wire ier_hit = er_info && ((cnt >> IBLK_AW) == '0);

  assign busy_o = (st != fsq_pkg::ST_IDLE) || q_valid;
  assign full_o = q_valid && (st != fsq_pkg::ST_IDLE);
  assign main_rdata_o = main_mem[main_raddr_i];
  assign info_rdata_o = info_mem[info_raddr_i];

  // Sequencer: erase walks one word per cycle, program waits out its timer
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= fsq_pkg::ST_IDLE;
      cnt <= '0;
      mask <= '0;
      base <= '0;
      ibase <= '0;
      er_info <= 1'b0;
      a_info <= 1'b0;
      a_addr <= '0;
      a_iaddr <= '0;
      a_data <= 16'h0000;
    end else begin
      unique case (st)
        fsq_pkg::ST_IDLE: begin
          cnt <= '0;
          if (cmd_valid_i && !is_prog) begin
            st <= fsq_pkg::ST_ERASE;
            mask <= (cmd_kind_i == fsq_pkg::CMD_PAGE) ? PG_MASK : '1;
            base <= cmd_addr_i;
            ibase <= cmd_iaddr_i;
            er_info <= (cmd_kind_i == fsq_pkg::CMD_INFO);
          end else if (q_valid) begin
            st <= fsq_pkg::ST_PROG;
            a_info <= q_info;
            a_addr <= q_addr;
            a_iaddr <= q_iaddr;
            a_data <= q_data;
          end
        end
        fsq_pkg::ST_ERASE: begin
          cnt <= cnt + 1'b1;
          if (er_last) begin
            st <= fsq_pkg::ST_IDLE;
          end
        end
        fsq_pkg::ST_PROG: begin
          cnt <= cnt + 1'b1;
          if (pr_last) begin
            st <= fsq_pkg::ST_IDLE;
          end
        end
        default: begin
          st <= fsq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Pipeline slot: a new word loads while the previous one programs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_valid <= 1'b0;
      q_info <= 1'b0;
      q_addr <= '0;
      q_iaddr <= '0;
      q_data <= 16'h0000;
    end else if (cmd_valid_i && is_prog) begin
      q_valid <= 1'b1;
      q_info <= (cmd_kind_i == fsq_pkg::CMD_PINFO);
      q_addr <= cmd_addr_i;
      q_iaddr <= cmd_iaddr_i;
      q_data <= cmd_data_i;
    end else if (st == fsq_pkg::ST_IDLE) begin
      q_valid <= 1'b0;
    end
  end

  // Array writes: erase forces ones, programming can only clear bits
  always_ff @(posedge clk_i) begin
    if (st == fsq_pkg::ST_ERASE) begin
      main_mem[er_addr] <= 16'hFFFF;
      if (ier_hit) begin
        info_mem[ier_addr] <= 16'hFFFF;
      end
    end else if (st == fsq_pkg::ST_PROG && pr_last) begin
      if (a_info) begin
        info_mem[a_iaddr] <= info_mem[a_iaddr] & a_data;
      end else begin
        main_mem[a_addr] <= main_mem[a_addr] & a_data;
      end
    end
  end
endmodule

//--- core/fsq_top.sv
// Purpose: flash interface registers, protection checks and reset word copy
// Assumes: CPU master holds a request while CPU_WAIT_O is high
// Notes: index 0 is the program flash, index 1 the data flash
`timescale 1ns/1ps
module fsq_top #(
  parameter int PROG_CYC = fsq_pkg::PROG_CYC
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // CPU memory bus
  input wire logic [23:0] CPU_ADDR_I,
  input wire logic CPU_RD_I,
  input wire logic CPU_WR_I,
  input wire logic CPU_BYTE_I,
  input wire logic [15:0] CPU_WDATA_I,
  output logic [15:0] CPU_RDATA_O,
  output logic CPU_ACK_O,
  output logic CPU_WAIT_O,
  // Transceiver power control
  input wire logic USB_CTRL_AWAKE_I,
  input wire logic USB_CFG_EN_I,
  output logic XCVR_LOWPWR_O
);
  logic [15:0] info_addr [2]; // Info address registers
  logic [15:0] ctrl [2]; // Control registers
  logic [1:0] efail; // Sticky erase failure
  logic [1:0] pfail; // Sticky program failure
  logic [15:0] wen0; // Program block 0 section enables
  logic [15:0] wen1; // Program block 1 section enables
  logic [15:0] dwen; // Data block section enables
  logic [15:0] mirror; // Function word copy
  logic [15:0] prot; // Protection word copy
  fsq_pkg::fsq_ld_t ld; // Reset-time loader
  logic [15:0] next_rdata;
  logic [1:0] busy;
  logic [1:0] full;
  logic [15:0] p_main_rd;
  logic [15:0] p_info_rd;
  logic [15:0] d_main_rd;
  logic [15:0] d_info_rd;

  // Address decode
  wire [23:0] a = CPU_ADDR_I;
  wire pm = (a >= fsq_pkg::PROG_MAIN_BASE) && (a <= fsq_pkg::PROG_MAIN_END);
  wire dm = (a >= fsq_pkg::DATA_MAIN_BASE) && (a <= fsq_pkg::DATA_MAIN_END);
  wire s_pia = (a == fsq_pkg::OFF_P_INFO_ADDR);
  wire s_piw = (a == fsq_pkg::OFF_P_INFO_WORD);
  wire s_pw0 = (a == fsq_pkg::OFF_P_WEN0);
  wire s_pw1 = (a == fsq_pkg::OFF_P_WEN1);
  wire s_pc = (a == fsq_pkg::OFF_P_CTRL);
  wire s_ps = (a == fsq_pkg::OFF_P_STAT);
  wire s_pm = (a == fsq_pkg::OFF_P_MIRROR);
  wire s_dia = (a == fsq_pkg::OFF_D_INFO_ADDR);
  wire s_diw = (a == fsq_pkg::OFF_D_INFO_WORD);
  wire s_dw = (a == fsq_pkg::OFF_D_WEN);
  wire s_dc = (a == fsq_pkg::OFF_D_CTRL);
  wire s_ds = (a == fsq_pkg::OFF_D_STAT);

  // Operation mode per flash, page erase ahead of block erase ahead of program
  wire [1:0] m_page;
  wire [1:0] m_blk;
  wire [1:0] m_prog;
  wire [1:0] m_erase;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_mode
      assign m_page[gi] = ctrl[gi][fsq_pkg::CTRL_PAGE_ER];
      assign m_blk[gi] = ctrl[gi][fsq_pkg::CTRL_BLOCK_ER] && !m_page[gi];
      assign m_prog[gi] = ctrl[gi][fsq_pkg::CTRL_PROG_EN] && !m_page[gi] && !m_blk[gi];
      assign m_erase[gi] = m_page[gi] || m_blk[gi];
    end
  endgenerate

  // Global lock and boot area from the protection word copy
  wire [2:0] wrp = prot[fsq_pkg::PW_WRP_MSB:fsq_pkg::PW_WRP_LSB];
  wire lock = (!wrp[2] && !wrp[1]) || (!wrp[2] && !wrp[0]) || (!wrp[1] && !wrp[0]);
  wire [3:0] boot_n = ~prot[fsq_pkg::PW_BOOT_MSB:fsq_pkg::PW_BOOT_LSB];
  wire [17:0] boot_end = {3'b000, boot_n, 11'h000}; // Bytes reserved from address 0
  wire boot_any = (boot_n != 4'h0);

  // Program flash legality checks
  wire p_blk = a[17];
  wire [3:0] p_sec = a[16:13];
  wire p_sec_en = p_blk ? wen1[p_sec] : wen0[p_sec];
  wire p_all_en = p_blk ? (&wen1) : (&wen0);
  wire p_pg_boot = ({a[17:10], 10'h000} < boot_end);
  wire p_wd_boot = (a[17:0] < boot_end);
  wire p_ok_page = !lock && p_sec_en && !p_pg_boot;
  wire p_ok_blk = !lock && p_all_en && !(!p_blk && boot_any);
  wire p_ok_prog = !lock && p_sec_en && !p_wd_boot && !CPU_BYTE_I;
  wire p_iblk = info_addr[0][7];
  wire p_ok_ier = !lock && p_iblk && (&wen1);
  wire p_ok_ipr = !lock && p_iblk && !CPU_BYTE_I;
  // Data flash legality checks, no boot area in this array
  wire [3:0] d_sec = a[12:9];
  wire d_ok_sec = !lock && dwen[d_sec];
  wire d_ok_blk = !lock && (&dwen);
  wire d_ok_ier = d_ok_blk;
  wire d_ok_ipr = !lock && !CPU_BYTE_I;

  // Array targets of a write: main window or info data register
  wire [1:0] tgt_main = {dm, pm};
  wire [1:0] tgt_info = {s_diw, s_piw};
  wire [1:0] tgt = tgt_main | tgt_info;
  // Erase may start only when idle, a program word only when not full
  wire [1:0] wr_stall = (m_erase & busy) | (m_prog & full);

  // Bus wait: loader, busy interlocks on reads, pipeline back-pressure
  wire loading = (ld != fsq_pkg::LD_DONE);
  wire rd_stall = (pm && busy[0]) || (dm && (busy[0] || busy[1]))
    || (s_piw && busy[0]) || (s_diw && busy[1]);
  assign CPU_WAIT_O = loading || (CPU_RD_I && rd_stall) || (CPU_WR_I && |(tgt & wr_stall));
  wire rd_take = CPU_RD_I && !CPU_WAIT_O;
  wire wr_take = CPU_WR_I && !CPU_WAIT_O;

  // Request classification per flash
  wire [1:0] w_arr = tgt & {2{wr_take}};
  wire [1:0] req_er = w_arr & ((tgt_main & m_erase) | (tgt_info & m_erase));
  wire [1:0] req_pr = w_arr & m_prog;
  wire p_ok = pm ? (m_page[0] ? p_ok_page : m_blk[0] ? p_ok_blk : p_ok_prog)
    : (m_page[0] ? 1'b0 : m_blk[0] ? p_ok_ier : p_ok_ipr);
  wire d_ok = dm ? (m_blk[1] ? d_ok_blk : d_ok_sec)
    : (m_page[1] ? 1'b0 : m_blk[1] ? d_ok_ier : d_ok_ipr);
  wire [1:0] ok = {d_ok, p_ok};
  wire [1:0] go = (req_er | req_pr) & ok;
  wire [1:0] e_set = req_er & ~ok;
  wire [1:0] p_set = req_pr & ~ok;

  // Engine commands
  wire fsq_pkg::fsq_cmd_t p_kind = pm ? (m_page[0] ? fsq_pkg::CMD_PAGE
    : m_blk[0] ? fsq_pkg::CMD_BLOCK : fsq_pkg::CMD_PMAIN)
    : (m_blk[0] ? fsq_pkg::CMD_INFO : fsq_pkg::CMD_PINFO);
  wire fsq_pkg::fsq_cmd_t d_kind = dm ? (m_page[1] ? fsq_pkg::CMD_PAGE
    : m_blk[1] ? fsq_pkg::CMD_BLOCK : fsq_pkg::CMD_PMAIN)
    : (m_blk[1] ? fsq_pkg::CMD_INFO : fsq_pkg::CMD_PINFO);
  wire [16:0] p_caddr = pm ? a[17:1] : {p_iblk, 16'h0000}; // Info erase hits its block
  wire [11:0] d_caddr = dm ? a[12:1] : 12'h000;
  wire [6:0] p_iraddr = (ld == fsq_pkg::LD_FW) ? fsq_pkg::FW_WORD
    : (ld == fsq_pkg::LD_PW) ? fsq_pkg::PW_WORD : info_addr[0][7:1];

  // Program flash: two main blocks and two info blocks
  fsq_engine #(
    .MAIN_AW(17),
    .BLK_AW(16),
    .PAGE_AW(9),
    .INFO_AW(7),
    .IBLK_AW(6),
    .PROG_CYC(PROG_CYC)
  ) u_prog (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .cmd_valid_i(go[0]),
    .cmd_kind_i(p_kind),
    .cmd_addr_i(p_caddr),
    .cmd_iaddr_i(info_addr[0][7:1]),
    .cmd_data_i(CPU_WDATA_I),
    .busy_o(busy[0]),
    .full_o(full[0]),
    .main_raddr_i(a[17:1]),
    .main_rdata_o(p_main_rd),
    .info_raddr_i(p_iraddr),
    .info_rdata_o(p_info_rd)
  );

  // Data flash: one main block and one info block
  fsq_engine #(
    .MAIN_AW(12),
    .BLK_AW(12),
    .PAGE_AW(8),
    .INFO_AW(6),
    .IBLK_AW(6),
    .PROG_CYC(PROG_CYC)
  ) u_data (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .cmd_valid_i(go[1]),
    .cmd_kind_i(d_kind),
    .cmd_addr_i(d_caddr),
    .cmd_iaddr_i(info_addr[1][6:1]),
    .cmd_data_i(CPU_WDATA_I),
    .busy_o(busy[1]),
    .full_o(full[1]),
    .main_raddr_i(a[12:1]),
    .main_rdata_o(d_main_rd),
    .info_raddr_i(info_addr[1][6:1]),
    .info_rdata_o(d_info_rd)
  );

  // Status words
  wire [15:0] p_stat = {12'h000, full[0], pfail[0], efail[0], busy[0]};
  wire [15:0] d_stat = {12'h000, full[1], pfail[1], efail[1], busy[1]};
  wire [15:0] p_mw = a[0] ? {8'h00, p_main_rd[15:8]} : {8'h00, p_main_rd[7:0]};
  wire [15:0] d_mw = a[0] ? {8'h00, d_main_rd[15:8]} : {8'h00, d_main_rd[7:0]};

  // Read mux; byte reads of the main arrays return the addressed byte in the low lane
  always_comb begin
    next_rdata = 16'h0000; // Unmapped addresses read zero
    if (pm) begin
      next_rdata = CPU_BYTE_I ? p_mw : p_main_rd;
    end else if (dm) begin
      next_rdata = CPU_BYTE_I ? d_mw : d_main_rd;
    end else if (s_pia) begin
      next_rdata = info_addr[0];
    end else if (s_piw) begin
      next_rdata = p_info_rd;
    end else if (s_pw0) begin
      next_rdata = wen0;
    end else if (s_pw1) begin
      next_rdata = wen1;
    end else if (s_pc) begin
      next_rdata = ctrl[0];
    end else if (s_ps) begin
      next_rdata = p_stat;
    end else if (s_pm) begin
      next_rdata = mirror;
    end else if (s_dia) begin
      next_rdata = info_addr[1];
    end else if (s_diw) begin
      next_rdata = d_info_rd;
    end else if (s_dw) begin
      next_rdata = dwen;
    end else if (s_dc) begin
      next_rdata = ctrl[1];
    end else if (s_ds) begin
      next_rdata = d_stat;
    end
  end

  // Bus answer: one-cycle ack after every taken access
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      CPU_RDATA_O <= fsq_pkg::REG_RST;
      CPU_ACK_O <= 1'b0;
    end else begin
      CPU_ACK_O <= rd_take || wr_take;
      if (rd_take) begin
        CPU_RDATA_O <= next_rdata;
      end
    end
  end

  // Software-written registers; section enables clear at reset
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      info_addr[0] <= fsq_pkg::REG_RST;
      info_addr[1] <= fsq_pkg::REG_RST;
      ctrl[0] <= fsq_pkg::REG_RST;
      ctrl[1] <= fsq_pkg::REG_RST;
      wen0 <= fsq_pkg::REG_RST;
      wen1 <= fsq_pkg::REG_RST;
      dwen <= fsq_pkg::REG_RST;
    end else if (wr_take) begin
      if (s_pia) info_addr[0] <= CPU_WDATA_I;
      if (s_dia) info_addr[1] <= CPU_WDATA_I;
      if (s_pc) ctrl[0] <= CPU_WDATA_I & fsq_pkg::CTRL_MASK;
      if (s_dc) ctrl[1] <= CPU_WDATA_I & fsq_pkg::CTRL_MASK;
      if (s_pw0) wen0 <= CPU_WDATA_I;
      if (s_pw1) wen1 <= CPU_WDATA_I;
      if (s_dw) dwen <= CPU_WDATA_I;
    end
  end

  // Sticky error flags: write one to clear, a new start of the same kind
  // clears too, and a refusal in the same cycle wins over both
  wire [1:0] e_clr = ({s_ds, s_ps} & {2{wr_take && CPU_WDATA_I[fsq_pkg::STAT_EFAIL]}})
    | (go & req_er);
  wire [1:0] p_clr = ({s_ds, s_ps} & {2{wr_take && CPU_WDATA_I[fsq_pkg::STAT_PFAIL]}})
    | (go & req_pr);
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      efail <= 2'b00;
      pfail <= 2'b00;
    end else begin
      efail <= e_set | (efail & ~e_clr);
      pfail <= p_set | (pfail & ~p_clr);
    end
  end

  // Reset-time copy of function and protection words; the bus waits
  // meanwhile so no access sees a half-loaded lock
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      ld <= fsq_pkg::LD_FW;
      mirror <= fsq_pkg::REG_RST;
      prot <= fsq_pkg::REG_RST;
    end else begin
      unique case (ld)
        fsq_pkg::LD_FW: begin
          mirror <= p_info_rd;
          ld <= fsq_pkg::LD_PW;
        end
        fsq_pkg::LD_PW: begin
          prot <= p_info_rd;
          ld <= fsq_pkg::LD_DONE;
        end
        fsq_pkg::LD_DONE: begin
          ld <= fsq_pkg::LD_DONE;
        end
        default: begin
          ld <= fsq_pkg::LD_DONE;
        end
      endcase
    end
  end

  // Transceiver held in low power unless the function word allows it and both USB_CTRL_AWAKE_I and USB_CFG_EN_I are high
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      XCVR_LOWPWR_O <= 1'b1;
    end else begin
      XCVR_LOWPWR_O <= !mirror[fsq_pkg::FW_USB_EN]
        || !(USB_CTRL_AWAKE_I && USB_CFG_EN_I);
    end
  end
endmodule

//--- tb/fsq_checker.sv
// Purpose: port checks of the flash sequencer bus and reset copy
// Assumes: one clock, reset active high
// Notes: busy is hidden here, so checks tie answers to taken requests
`timescale 1ns/1ps
module fsq_checker #(
  parameter int PROG_CYC = 8
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // CPU bus
  input wire logic [23:0] CPU_ADDR_I,
  input wire logic CPU_RD_I,
  input wire logic CPU_WR_I,
  input wire logic CPU_BYTE_I,
  input wire logic [15:0] CPU_WDATA_I,
  input wire logic [15:0] CPU_RDATA_O,
  input wire logic CPU_ACK_O,
  input wire logic CPU_WAIT_O,
  // Transceiver
  input wire logic USB_CTRL_AWAKE_I,
  input wire logic USB_CFG_EN_I,
  input wire logic XCVR_LOWPWR_O
);
  // Request taken at this edge
  wire take = (CPU_RD_I || CPU_WR_I) && !CPU_WAIT_O;
  wire rd_take = CPU_RD_I && !CPU_WAIT_O;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_take_acked: assert property (take |=> CPU_ACK_O)
    else $error("ack missing after taken request");
  a_ack_caused: assert property (CPU_ACK_O |-> $past(take))
    else $error("ack without a taken request");
  a_rdata_held: assert property (!($past(CPU_RD_I) && CPU_ACK_O)
    |-> $stable(CPU_RDATA_O))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd_take && CPU_ADDR_I == 24'hFF_F764
    |=> CPU_RDATA_O == 16'h0000)
    else $error("unmapped read not zero");
  a_byte_high_zero: assert property (rd_take && CPU_BYTE_I
    && CPU_ADDR_I <= fsq_pkg::PROG_MAIN_END |=> CPU_RDATA_O[15:8] == 8'h00)
    else $error("byte read upper half not zero");
  a_stat_reserved: assert property (rd_take && CPU_ADDR_I == fsq_pkg::OFF_P_STAT
    |=> CPU_RDATA_O[15:4] == 12'h000)
    else $error("status reserved bits set");
  a_ctrl_reserved: assert property (rd_take && CPU_ADDR_I == fsq_pkg::OFF_P_CTRL
    |=> (CPU_RDATA_O & ~fsq_pkg::CTRL_MASK) == 16'h0000)
    else $error("control reserved bits set");
  a_load_wait: assert property ($fell(SYS_RST_I)
    |-> CPU_WAIT_O ##1 CPU_WAIT_O ##1 !CPU_WAIT_O)
    else $error("wait wrong during word copy");
  a_lowpwr_reset: assert property ($fell(SYS_RST_I)
    |-> XCVR_LOWPWR_O && !CPU_ACK_O)
    else $error("reset values wrong");
  // Main scenarios reached
  cover property (take && CPU_WR_I);
  cover property (CPU_RD_I && CPU_WAIT_O);
  cover property (rd_take && CPU_BYTE_I);
endmodule
bind fsq_top fsq_checker #(.PROG_CYC(PROG_CYC)) fsq_checker_i (.CLK_I, .SYS_RST_I, .CPU_ADDR_I,
  .CPU_RD_I, .CPU_WR_I, .CPU_BYTE_I, .CPU_WDATA_I, .CPU_RDATA_O, .CPU_ACK_O, .CPU_WAIT_O,
  .USB_CTRL_AWAKE_I, .USB_CFG_EN_I, .XCVR_LOWPWR_O);

//--- tb/fsq_cpu_model.sv
// Purpose: CPU master model on the sequencer memory bus
// Assumes: one request at a time, whole-word writes to the arrays
// Notes: released lines carry inverted junk so stale values never pass
`timescale 1ns/1ps
module fsq_cpu_model (
  // Clock and answer
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [15:0] rdata_i,
  // Request
  output logic [23:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic byte_o,
  output logic [15:0] wdata_o
);
  // Quiet bus at time zero
  initial begin
    {addr_o, rd_o, wr_o, byte_o, wdata_o} = '0;
  end
  // Request held until ack shows it was taken; the wait covers busy and full
  task automatic acc(input logic w, input logic b, input logic [23:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    @(negedge clk_i);
    {addr_o, wdata_o, byte_o, rd_o, wr_o} = {a, d, b, !w, w};
    do begin
      @(negedge clk_i);
      n++;
    end while (!ack_i && n < 70000);
    q = rdata_i;
    {addr_o, wdata_o, rd_o, wr_o} = {~a, ~d, 2'b00};
  endtask
endmodule

//--- tb/tb_fsq_top.sv
// Purpose: directed tests of reads, erase, program and word copy
// Assumes: arrays preloaded through hierarchy while reset is held
// Notes: array reads stall on busy, so they double as busy waits
`timescale 1ns/1ps
module tb_fsq_top;
  logic clk = 0;
  logic rst = 1;
  logic awake = 0;
  logic cfg = 0;
  logic [23:0] addr;
  logic rd, wr, bt, ack, wt, lp;
  logic [15:0] wd, rdata;
  int err_count = 0;
  int compares = 0;
  always #2.5 clk = ~clk;
  fsq_top fsq_top_i (.CLK_I(clk), .SYS_RST_I(rst), .CPU_ADDR_I(addr), .CPU_RD_I(rd),
    .CPU_WR_I(wr), .CPU_BYTE_I(bt), .CPU_WDATA_I(wd), .CPU_RDATA_O(rdata), .CPU_ACK_O(ack),
    .CPU_WAIT_O(wt), .USB_CTRL_AWAKE_I(awake), .USB_CFG_EN_I(cfg), .XCVR_LOWPWR_O(lp));
  fsq_cpu_model fsq_cpu_model_i (.clk_i(clk), .ack_i(ack), .rdata_i(rdata), .addr_o(addr),
    .rd_o(rd), .wr_o(wr), .byte_o(bt), .wdata_o(wd));
  // Compare and count
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // Whole-word write
  task automatic w(input logic [23:0] a, input logic [15:0] d);
    logic [15:0] q;
    fsq_cpu_model_i.acc(1'b1, 1'b0, a, d, q);
  endtask
  // Read and compare
  task automatic r(input logic [23:0] a, input logic [15:0] e, input logic b = 1'b0);
    logic [15:0] q;
    fsq_cpu_model_i.acc(1'b0, b, a, 16'h0000, q);
    chk($sformatf("read %h", a), e, q);
  endtask
  task give_verdict;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard, far above the ten thousand or so cycles the tests need
  initial begin
    #200000;
    err_count++;
    give_verdict;
  end
  initial begin
    #1;
    fsq_top_i.u_prog.info_mem[7'h3F] = 16'hC3A0;
    fsq_top_i.u_prog.info_mem[7'h7F] = 16'hE01E;
    fsq_top_i.u_prog.main_mem[17'h0_01FF] = 16'h4321;
    fsq_top_i.u_prog.main_mem[17'h0_03FF] = 16'h0000;
    fsq_top_i.u_prog.main_mem[17'h0_0400] = 16'h1234;
    fsq_top_i.u_prog.main_mem[17'h0_1000] = 16'h5A5A;
    fsq_top_i.u_data.main_mem[0] = 16'h7777;
    fsq_top_i.u_prog.info_mem[7'h08] = 16'hFFFF;
    fsq_top_i.u_data.info_mem[6'h02] = 16'h0000;
    repeat (2) @(negedge clk);
    rst = 0;
    r(24'hFF_F964, 16'hC3A0);
    chk("lowpwr", 16'h0001, {15'h0000, lp});
    r(24'hFF_F764, 16'h0000);
    w(24'hFF_F940, 16'h007E);
    r(24'hFF_F942, 16'hC3A0);
    w(24'hFF_F940, 16'h00FE);
    r(24'hFF_F942, 16'hE01E);
    $display("test reset and info done");
    w(24'hFF_F944, 16'h0001);
    w(24'hFF_F94C, 16'h0004);
    r(24'hFF_F94C, 16'h0004);
    w(24'h00_0400, 16'h0000);
    r(24'hFF_F94E, 16'h0001);
    r(24'h00_07FE, 16'hFFFF);
    r(24'hFF_F94E, 16'h0000);
    r(24'h00_0800, 16'h1234);
    r(24'h00_03FE, 16'h4321);
    r(24'h00_07FF, 16'h00FF, 1'b1);
    w(24'h00_2000, 16'h0000);
    r(24'hFF_F94E, 16'h0002);
    r(24'h00_2000, 16'h5A5A);
    r(24'hFF_F94E, 16'h0002);
    w(24'hFF_F94E, 16'h0002);
    r(24'hFF_F94E, 16'h0000);
    $display("test page erase done");
    w(24'hFF_F94C, 16'h0002);
    w(24'h00_0400, 16'h0F0F);
    w(24'h00_0402, 16'hAAAA);
    r(24'hFF_F94E, 16'h0009);
    r(24'h0D_0000, 16'h7777);
    r(24'hFF_F94E, 16'h0000);
    r(24'h00_0400, 16'h0F0F);
    r(24'h00_0402, 16'hAAAA);
    w(24'h00_0400, 16'hF0F0);
    r(24'h00_0400, 16'h0000);
    w(24'hFF_F940, 16'h0010);
    w(24'hFF_F942, 16'h1111);
    r(24'hFF_F94E, 16'h0004);
    r(24'hFF_F942, 16'hFFFF);
    w(24'hFF_F94C, 16'h0000);
    r(24'hFF_F94C, 16'h0000);
    $display("test program done");
    w(24'hFF_F744, 16'hFFFF);
    w(24'hFF_F74C, 16'h0008);
    w(24'h0D_0002, 16'h0000);
    r(24'hFF_F74E, 16'h0001);
    r(24'h0D_0000, 16'hFFFF);
    r(24'hFF_F74E, 16'h0000);
    w(24'hFF_F740, 16'h0004);
    w(24'hFF_F742, 16'h0000);
    r(24'hFF_F742, 16'hFFFF);
    $display("test data erase done");
    @(negedge clk);
    rst = 1;
    fsq_top_i.u_prog.info_mem[7'h3F] = 16'h0001;
    awake = 1;
    cfg = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    repeat (4) @(negedge clk);
    r(24'hFF_F964, 16'h0001);
    chk("lowpwr", 16'h0000, {15'h0000, lp});
    $display("test second reset done");
    give_verdict;
  end
endmodule
